// ---- src/dsl_top.sv ----
`timescale 1ns/1ps
module dsl_top #(
	// Arbitrary key value
	parameter logic [dsl_pkg::KEY_W-1:0] LOCK_KEY = 32'h5a5a_a5a5,
	parameter logic [dsl_pkg::SEQ_W-1:0] SEQ_TO_JTAG = dsl_pkg::SEQ_TO_JTAG_DEF,
	parameter logic [dsl_pkg::SEQ_W-1:0] SEQ_TO_SWD = dsl_pkg::SEQ_TO_SWD_DEF
) (
	// Clocks and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic link_clk,
	// Debug data pin
	input wire logic link_data_in,
	output logic link_data_out,
	output logic link_data_oe,
	// Firmware controls
	input wire logic fw_debug_enable,
	input wire logic usb_pair_select,
	input wire dsl_pkg::dsl_trace_t trace_mode,
	// Flash protection and erase
	input wire logic chip_erase_done,
	input wire dsl_pkg::dsl_prot_req_t prot_req,
	input wire logic blk_op_req,
	input wire logic blk_op_protected,
	// Latch key path
	input wire logic key_write,
	input wire logic [dsl_pkg::KEY_W-1:0] key_data,
	input wire logic key_program,
	input wire logic [dsl_pkg::KEY_W-1:0] nonvolatile_latch_cell,
	// Status and pin enables
	output dsl_pkg::dsl_pins_t pin_en,
	output dsl_pkg::dsl_port_t active_port,
	output logic debug_trace_en,
	output logic device_locked,
	output logic [1:0] prot_level,
	output logic blk_op_grant,
	output logic key_accept,
	output logic nv_prog_req,
	output logic [dsl_pkg::KEY_W-1:0] nv_prog_data,
	output logic [2:0] prog_bp_count,
	output logic [1:0] lit_bp_count
);
	import dsl_pkg::*;

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic key_match(input logic [KEY_W-1:0] bits);
		logic [5:0] hits;
		hits = 6'h00;
		for (int i = 0; i < KEY_W; i++) begin
			hits = hits + {5'h00, ~(bits[i] ^ LOCK_KEY[i])};
		end
		return hits >= 6'(MATCH_MIN);
	endfunction : key_match

	function automatic logic sync_edge(input logic a, input logic b);
		return a ^ b;
	endfunction : sync_edge

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [KEY_W-1:0] nv_meta;
	logic [KEY_W-1:0] nv_sync;
	logic seq_jtag_meta;
	logic seq_jtag_sync;
	logic seq_jtag_seen;
	logic seq_swd_meta;
	logic seq_swd_sync;
	logic seq_swd_seen;
	logic link_to_jtag_tgl;
	logic link_to_swd_tgl;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nv_meta <= '0;
			nv_sync <= '0;
		end else begin
			nv_meta <= nonvolatile_latch_cell;
			nv_sync <= nv_meta;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			seq_jtag_meta <= 1'b0;
			seq_jtag_sync <= 1'b0;
			seq_jtag_seen <= 1'b0;
			seq_swd_meta <= 1'b0;
			seq_swd_sync <= 1'b0;
			seq_swd_seen <= 1'b0;
		end else begin
			seq_jtag_meta <= link_to_jtag_tgl;
			seq_jtag_sync <= seq_jtag_meta;
			seq_jtag_seen <= seq_jtag_sync;
			seq_swd_meta <= link_to_swd_tgl;
			seq_swd_sync <= seq_swd_meta;
			seq_swd_seen <= seq_swd_sync;
		end
	end

	// ************************************************************
	// Lock sampling after reset
	// ************************************************************
	dsl_state_t state;
	dsl_state_t next_state;
	logic [1:0] sample_cnt;
	logic locked;

	always_comb begin
		next_state = state;
		case (state)
			DSL_ST_WAIT: begin
				if (sample_cnt == 2'(SAMPLE_DELAY - 1)) begin
					next_state = DSL_ST_SAMPLE;
				end
			end
			DSL_ST_SAMPLE: begin
				next_state = DSL_ST_RUN;
			end
			DSL_ST_RUN: begin
				next_state = DSL_ST_RUN;
			end
			default: begin
				next_state = DSL_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= DSL_ST_WAIT;
			sample_cnt <= 2'h0;
		end else begin
			state <= next_state;
			if (state == DSL_ST_WAIT) begin
				sample_cnt <= sample_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			locked <= LOCK_RESET;
		end else if (state == DSL_ST_SAMPLE) begin
			locked <= key_match(nv_sync);
		end
	end

	logic access_ok;
	assign access_ok = (state == DSL_ST_RUN) && !locked;

	// ************************************************************
	// Port selection
	// ************************************************************
	dsl_port_t port;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			port <= DSL_PORT_SWD;
		end else if (sync_edge(seq_jtag_sync, seq_jtag_seen)) begin
			port <= DSL_PORT_JTAG;
		end else if (sync_edge(seq_swd_sync, seq_swd_seen)) begin
			port <= DSL_PORT_SWD;
		end
	end

	// ************************************************************
	// Debug and trace gating
	// ************************************************************
	logic dbg_en;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dbg_en <= 1'b0;
		end else if (fw_debug_enable) begin
			dbg_en <= 1'b1;
		end
	end

	dsl_pins_t next_pins;

	always_comb begin
		next_pins = '0;
		if (access_ok) begin
			next_pins.swd_gpio_en = (port == DSL_PORT_SWD) && !usb_pair_select;
			next_pins.swd_usb_en = (port == DSL_PORT_SWD) && usb_pair_select;
			next_pins.jtag_en = (port == DSL_PORT_JTAG);
			if (dbg_en) begin
				case (trace_mode)
					DSL_TR_SINGLE: begin
						next_pins.single_trace_en = (port == DSL_PORT_SWD);
					end
					DSL_TR_PARALLEL: begin
						next_pins.par_trace_en = '1;
					end
					default: begin
						next_pins.single_trace_en = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_en <= '0;
			active_port <= DSL_PORT_SWD;
			debug_trace_en <= 1'b0;
			device_locked <= LOCK_RESET;
		end else begin
			pin_en <= next_pins;
			active_port <= port;
			debug_trace_en <= dbg_en && access_ok;
			device_locked <= locked;
		end
	end

	// ************************************************************
	// Flash protection
	// ************************************************************
	logic erased;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prot_level <= PROT_RESET;
			erased <= 1'b0;
		end else if (chip_erase_done && !locked) begin
			prot_level <= PROT_RESET;
			erased <= 1'b1;
		end else if (prot_req.wr && access_ok) begin
			if (prot_req.level >= prot_level || erased) begin
				prot_level <= prot_req.level;
			end
			if (prot_req.level > prot_level) begin
				erased <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			blk_op_grant <= 1'b0;
		end else begin
			blk_op_grant <= blk_op_req && access_ok && !blk_op_protected;
		end
	end

	// ************************************************************
	// Write-once latch key path
	// ************************************************************
	// key only without protection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			key_accept <= 1'b0;
			nv_prog_data <= '0;
		end else begin
			key_accept <= key_write && access_ok && (prot_level == PROT_RESET);
			if (key_write && access_ok && (prot_level == PROT_RESET)) begin
				nv_prog_data <= key_data;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nv_prog_req <= 1'b0;
		end else begin
			nv_prog_req <= key_program && access_ok;
		end
	end

	// ************************************************************
	// Breakpoint resources
	// ************************************************************
	// six address, two literal
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prog_bp_count <= 3'h0;
			lit_bp_count <= 2'h0;
		end else begin
			prog_bp_count <= 3'(PROG_BP_NUM);
			lit_bp_count <= 2'(LIT_BP_NUM);
		end
	end

	// ************************************************************
	// Link clock domain
	// ************************************************************
	logic lock_meta;
	logic lock_sync;
	logic [SEQ_W-1:0] link_shift;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
		end else begin
			lock_meta <= access_ok;
			lock_sync <= lock_meta;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			link_shift <= '0;
		end else if (lock_sync) begin
			link_shift <= {link_data_in, link_shift[SEQ_W-1:1]};
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			link_to_jtag_tgl <= 1'b0;
			link_to_swd_tgl <= 1'b0;
		end else if (lock_sync) begin
			if ({link_data_in, link_shift[SEQ_W-1:1]} == SEQ_TO_JTAG) begin
				link_to_jtag_tgl <= ~link_to_jtag_tgl;
			end
			if ({link_data_in, link_shift[SEQ_W-1:1]} == SEQ_TO_SWD) begin
				link_to_swd_tgl <= ~link_to_swd_tgl;
			end
		end
	end

	// Device never drives the data pin
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			link_data_out <= 1'b0;
			link_data_oe <= 1'b0;
		end else begin
			link_data_out <= 1'b0;
			link_data_oe <= 1'b0;
		end
	end
endmodule : dsl_top

// ---- src/dsl_pkg.sv ----
// Behaviour
// - Reset always selects two-wire debug port
// - Two-wire debug on one pin pair only
// - Host clock pin, bidirectional data pin; here link_data_oe stays low, so the data pin is input only
// - Switch sequences swap two-wire and JTAG
// - Debug and trace start disabled, firmware enables; here debug pins open at lock sampling, only trace waits for fw_debug_enable
// - Re-enable only via erase and reprogram
// - Lock disables every external port
// - Six address and two literal breakpoints
// - Debug accepted during reset and low power; here the link is ignored in reset and until the lock is sampled
// - Only three legal debug plus trace combos
// - Parallel trace five pins, single trace one
// - Protection lowered only after full erase
// - Block operations need permitting block security
// - Lock output when 28 of 32 match
// - Lock blocks debug, test and latch change
// - Lock needs load, program, then reset
// - Latch output sampled only at reset
// - Key write only with no protection
// - Access continues until next reset
package dsl_pkg;
	localparam int KEY_W = 32;
	localparam int MATCH_MIN = 28;
	localparam int SEQ_W = 16;
	localparam int PROG_BP_NUM = 6;
	localparam int LIT_BP_NUM = 2;
	localparam int PAR_TRACE_PINS = 5;
	localparam int CPU_CLK_NS = 4;
	// Max fraction of CPU clock for link clocks (divisors)
	localparam int SWD_CLK_DIV_MIN = 3;
	localparam int JTAG_DIV16_MIN = 3;
	localparam int JTAG_DIV32_MIN = 5;
	localparam int JTAG_MAX_MHZ = 8;
	localparam int SAMPLE_DELAY = 3;
	localparam logic [1:0] PROT_RESET = 2'h0;
	localparam logic LOCK_RESET = 1'b1;
	// Arbitrary values for the protocol switch words
	localparam logic [SEQ_W-1:0] SEQ_TO_JTAG_DEF = 16'he73c;
	localparam logic [SEQ_W-1:0] SEQ_TO_SWD_DEF = 16'he79e;

	typedef enum logic {
		DSL_PORT_SWD = 1'b0,
		DSL_PORT_JTAG = 1'b1
	} dsl_port_t;

	typedef enum logic [1:0] {
		DSL_TR_OFF = 2'h0,
		DSL_TR_SINGLE = 2'h1,
		DSL_TR_PARALLEL = 2'h3
	} dsl_trace_t;

	typedef enum logic [1:0] {
		DSL_ST_WAIT = 2'h0,
		DSL_ST_SAMPLE = 2'h1,
		DSL_ST_RUN = 2'h3
	} dsl_state_t;

	typedef struct packed {
		logic wr;
		logic [1:0] level;
	} dsl_prot_req_t;

	typedef struct packed {
		logic swd_gpio_en;
		logic swd_usb_en;
		logic jtag_en;
		logic single_trace_en;
		logic [PAR_TRACE_PINS-1:0] par_trace_en;
	} dsl_pins_t;
endpackage : dsl_pkg

// ---- verif/dsl_host.sv ----
`timescale 1ns/1ps
module dsl_host (
	// Link pins
	output logic link_clk,
	output logic link_data
);
	import dsl_pkg::*;
	initial begin
		link_clk = 1'b0;
		link_data = 1'b0;
	end
	task automatic send(input logic [SEQ_W-1:0] w);
		// Idle clocks with data high let the port enable settle
		for (int i = 0; i < 4; i++) begin
			link_data = 1'b1;
			#32 link_clk = 1'b1;
			#32 link_clk = 1'b0;
		end
		for (int i = 0; i < SEQ_W; i++) begin
			link_data = w[i];
			#32 link_clk = 1'b1;
			#32 link_clk = 1'b0;
		end
		// Released line shows no stale bit
		link_data = !w[SEQ_W-1];
	endtask : send
endmodule : dsl_host

// ---- verif/dsl_top_sva.sv ----
`timescale 1ns/1ps
module dsl_top_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Requests
	input wire logic key_write,
	input wire logic [dsl_pkg::KEY_W-1:0] key_data,
	input wire dsl_pkg::dsl_prot_req_t prot_req,
	input wire logic blk_op_req,
	input wire logic blk_op_protected,
	// Answers
	input wire logic device_locked,
	input wire logic key_accept,
	input wire logic [dsl_pkg::KEY_W-1:0] nv_prog_data,
	input wire logic [1:0] prot_level,
	input wire logic blk_op_grant,
	input wire dsl_pkg::dsl_pins_t pin_en,
	input wire logic [2:0] prog_bp_count,
	input wire logic [1:0] lit_bp_count
);
	import dsl_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_key_take: assert property (
		key_write && !device_locked && prot_level == 2'h0 |=>
		key_accept && nv_prog_data == $past(key_data)) else $error("key lost");
	chk_key_refuse: assert property (
		key_accept |-> $past(key_write && !device_locked && prot_level == 2'h0))
		else $error("key taken wrongly");
	chk_lock_pins: assert property (
		device_locked && $past(device_locked) |-> pin_en == 9'h000)
		else $error("pins open while locked");
	chk_lock_hold: assert property (
		!$past(device_locked) |-> !device_locked) else $error("lock moved");
	chk_blk_grant: assert property (
		blk_op_grant |-> $past(blk_op_req && !blk_op_protected && !device_locked))
		else $error("block grant wrong");
	chk_prot_raise: assert property (
		prot_req.wr && prot_req.level > prot_level && !device_locked |=>
		prot_level == $past(prot_req.level)) else $error("raise lost");
	chk_bp_count: assert property (
		!$past(rst) |-> prog_bp_count == 3'h6 && lit_bp_count == 2'h2)
		else $error("breakpoint count wrong");
	chk_pin_combo: assert property (
		!(pin_en.swd_gpio_en && pin_en.swd_usb_en) &&
		!(pin_en.single_trace_en && pin_en.jtag_en)) else $error("bad pin mix");
endmodule : dsl_top_sva

// ---- verif/tb_dsl_top.sv ----
`timescale 1ns/1ps
module tb_dsl_top;
	import dsl_pkg::*;
	// Arbitrary key value
	localparam logic [KEY_W-1:0] K = 32'h5a5aa5a5;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic link_clk, link_data_in, link_data_out, link_data_oe;
	logic fw_debug_enable = 1'b0, usb_pair_select = 1'b0;
	logic chip_erase_done = 1'b0, blk_op_req = 1'b0, blk_op_protected = 1'b0;
	logic key_write = 1'b0, key_program = 1'b0;
	logic [KEY_W-1:0] key_data = '0, nv_cell = '0, nv_prog_data;
	dsl_trace_t trace_mode = DSL_TR_OFF;
	dsl_prot_req_t prot_req = '0;
	dsl_pins_t pin_en;
	dsl_port_t active_port;
	logic debug_trace_en, device_locked, blk_op_grant, key_accept, nv_prog_req;
	logic [1:0] prot_level, lit_bp_count;
	logic [2:0] prog_bp_count;
	int errors = 0, total_checks = 0, cyc = 0;
	// Rows: usb select, trace mode, expected pin enables
	logic [11:0] rows [8] = '{12'h100, 12'h880, 12'h320, 12'h71f, 12'h500,
		12'h040, 12'h240, 12'h65f};
	dsl_top #(.LOCK_KEY(K)) dsl_top_inst (.ref_clk, .rst, .link_clk,
		.link_data_in, .link_data_out, .link_data_oe, .fw_debug_enable,
		.usb_pair_select, .trace_mode, .chip_erase_done, .prot_req, .blk_op_req,
		.blk_op_protected, .key_write, .key_data, .key_program,
		.nonvolatile_latch_cell(nv_cell), .pin_en, .active_port,
		.debug_trace_en, .device_locked, .prot_level, .blk_op_grant,
		.key_accept, .nv_prog_req, .nv_prog_data, .prog_bp_count,
		.lit_bp_count);
	dsl_host dsl_host_inst (.link_clk, .link_data(link_data_in));
	always #2 ref_clk = ~ref_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic do_reset();
		rst = 1'b1;
		tick(2);
		cmp({device_locked, active_port, pin_en}, 11'h400);
		tick(6);
		rst = 1'b0;
		tick(6);
		cmp({prog_bp_count, lit_bp_count}, 5'h1a);
	endtask : do_reset
	task automatic final_report();
		$display("Checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			final_report();
		end
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		do_reset();
		trace_mode = DSL_TR_SINGLE;
		tick(2);
		cmp({device_locked, debug_trace_en, pin_en}, 11'h100);
		fw_debug_enable = 1'b1;
		tick(1);
		fw_debug_enable = 1'b0;
		tick(2);
		cmp(debug_trace_en, 1'b1);
		for (int i = 0; i < 8; i++) begin
			if (i == 5) begin
				dsl_host_inst.send(SEQ_TO_JTAG_DEF);
				tick(10);
				cmp(active_port, DSL_PORT_JTAG);
			end
			usb_pair_select = rows[i][11];
			trace_mode = dsl_trace_t'(rows[i][10:9]);
			tick(2);
			cmp(pin_en, rows[i][8:0]);
		end
		dsl_host_inst.send(SEQ_TO_SWD_DEF);
		tick(10);
		cmp(active_port, DSL_PORT_SWD);
		dsl_host_inst.send(SEQ_TO_JTAG_DEF);
		tick(10);
		do_reset();
		cmp({debug_trace_en, pin_en}, 10'h100);
		blk_op_req = 1'b1;
		tick(1);
		cmp(blk_op_grant, 1'b1);
		blk_op_protected = 1'b1;
		tick(1);
		cmp(blk_op_grant, 1'b0);
		prot_req = '{wr: 1'b1, level: 2'h2};
		tick(1);
		prot_req.level = 2'h1;
		key_write = 1'b1;
		key_data = K;
		tick(1);
		cmp({prot_level, key_accept}, 3'h4);
		prot_req.wr = 1'b0;
		key_write = 1'b0;
		chip_erase_done = 1'b1;
		tick(1);
		chip_erase_done = 1'b0;
		tick(1);
		cmp(prot_level, 2'h0);
		key_write = 1'b1;
		key_program = 1'b1;
		tick(1);
		cmp({key_accept, nv_prog_req, nv_prog_data}, {2'h3, K});
		key_write = 1'b0;
		key_program = 1'b0;
		tick(1);
		cmp({key_accept, device_locked}, 2'h0);
		nv_cell = K ^ 32'h0000001f;
		do_reset();
		cmp(device_locked, 1'b0);
		nv_cell = K ^ 32'h0000000f;
		do_reset();
		cmp({device_locked, pin_en}, 10'h200);
		nv_cell = ~K;
		key_write = 1'b1;
		key_program = 1'b1;
		blk_op_protected = 1'b0;
		tick(1);
		cmp({key_accept, blk_op_grant}, 2'h0);
		cmp(nv_prog_req, 1'b0);
		key_write = 1'b0;
		key_program = 1'b0;
		blk_op_req = 1'b0;
		dsl_host_inst.send(SEQ_TO_JTAG_DEF);
		tick(10);
		cmp({device_locked, active_port, pin_en}, 11'h400);
		cmp({link_data_oe, link_data_out}, 2'h0);
		final_report();
	end
endmodule : tb_dsl_top
bind dsl_top dsl_top_sva dsl_top_sva_inst (.ref_clk, .rst, .key_write,
	.key_data, .prot_req, .blk_op_req, .blk_op_protected, .device_locked,
	.key_accept, .nv_prog_data, .prot_level, .blk_op_grant, .pin_en,
	.prog_bp_count, .lit_bp_count);
